// ### core/pinmux_pkg.sv
package pinmux_pkg;
   // Register offsets (byte addresses, one 8-bit register per word)
   localparam logic [5:0] ADDR_PDR_BASE = 6'h00;
   localparam logic [5:0] ADDR_DDR_BASE = 6'h10;
   localparam logic [5:0] ADDR_CTRL     = 6'h20;
   localparam logic [5:0] ADDR_STAT     = 6'h24;
   // Control register fields
   localparam int CTRL_UA_LSB    = 0;
   localparam int CTRL_WRL_BIT   = 4;
   localparam int CTRL_WRH_BIT   = 5;
   localparam int CTRL_BUS16_BIT = 6;
   localparam logic [6:0] CTRL_RESET = 7'h7F;
   // Status register fields
   localparam int STAT_EXT_BIT  = 0;
   localparam int STAT_STBY_BIT = 1;
   localparam int STAT_MODE_LSB = 2;
   // Port data and direction reset values
   localparam logic [7:0] PDR_RESET = 8'h00;
   localparam logic [7:0] DDR_RESET = 8'h00;
   // Mode pin code that selects single-chip operation
   localparam logic [2:0] MODE_SINGLE_CHIP = 3'h3;
   // Wake-up requests are low level; this is "no request"
   localparam logic [7:0] WAKE_IDLE = 8'hFF;
   localparam logic [7:0] ALL_ON    = 8'hFF;
   localparam logic [7:0] ALL_OFF   = 8'h00;

   typedef struct packed {
      logic [19:0] addr;
      logic        ale;
      logic        rd;
      logic        wr_lo;
      logic        wr_hi;
      logic [15:0] dout;
      logic        dout_en;
   } bus_req_t;

   typedef struct packed {
      logic       bus16;
      logic       wrh_en;
      logic       wrl_en;
      logic [3:0] ua_en;
   } bus_ctrl_t;
endpackage

// ### core/ext_bus_pin_mux.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// Overview of operation
// - Port 0 carries low address/data byte
// - Port 1 carries high address/data byte
// - Single-chip returns bus pins to ports
// - Single-chip port 1 feeds wake-up inputs
// - Upper address pins are ports unless selected
// - Address 16-19 driven in bus mode only
// - Event pins are ports, also timer inputs
// - Timer outputs override port when enabled
// - Bus mode drives address latch enable
// - Bus mode drives read strobe
// - Low write strobe pin gated by enable
// - Low strobe serves lower or single byte
// - High write strobe only 16-bit bus mode
// - High strobe pin otherwise a port
// - Mode taken from three mode pins
// - Reset request pin raises reset request
// - Standby pin enters hardware standby
module ext_bus_pin_mux (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   // Register port
   input  wire logic [5:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   // Bus controller and timers
   input  wire pinmux_pkg::bus_req_t bus_req,
   output logic      [15:0]          bus_din,
   input  wire logic [1:0]           reload_timer_out,
   input  wire logic [1:0]           reload_timer_out_en,
   output logic      [1:0]           reload_timer_event_in,
   output logic      [7:0]           wakeup_irq_inputs,
   // Static pins
   input  wire logic [2:0]           mode_select_pins,
   input  wire logic                 hw_standby_in,
   input  wire logic                 reset_req_pin_b,
   output logic                      hw_standby_active,
   output logic                      reset_request,
   // Port pins
   input  wire logic [7:0]           port0_pins_in,
   output logic      [7:0]           port0_pins_out,
   output logic      [7:0]           port0_pins_oe,
   input  wire logic [7:0]           port1_pins_in,
   output logic      [7:0]           port1_pins_out,
   output logic      [7:0]           port1_pins_oe,
   input  wire logic [7:0]           port2_pins_in,
   output logic      [7:0]           port2_pins_out,
   output logic      [7:0]           port2_pins_oe,
   input  wire logic [3:0]           port3_pins_in,
   output logic      [3:0]           port3_pins_out,
   output logic      [3:0]           port3_pins_oe
);

   ////////////////////////////////////////////////////////////////////////////
   localparam int RAW_W = 33;
   // Idle pin levels: single-chip mode, no reset request, no wake-up request
   localparam logic [RAW_W-1:0] RAW_IDLE = {pinmux_pkg::MODE_SINGLE_CHIP, 1'h0, 1'h1, 4'h0,
                                            8'h00, pinmux_pkg::WAKE_IDLE, 8'h00};

   logic [RAW_W-1:0]      raw_s1_q;
   logic [RAW_W-1:0]      raw_s2_q;
   logic [7:0]            pin_s [4];
   logic [2:0]            mode_s;
   logic                  stby_s;
   logic                  rstreq_b_s;
   logic                  ext_mode_q;
   logic                  stby_q;
   logic [2:0]            mode_q;
   logic [7:0]            pdr_q [4];
   logic [7:0]            ddr_q [4];
   pinmux_pkg::bus_ctrl_t ctrl_q;
   logic [7:0]            out_d [4];
   logic [7:0]            oe_d [4];
   logic [7:0]            rdata_d;

   function automatic logic in_bank(input logic [5:0] a, input logic [5:0] base);
      in_bank = (a[5:4] == base[5:4]) && (a[1:0] == 2'h0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pins are asynchronous; only the second stage is read
   // Reset to idle levels, else bus mode and requests flash up after reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         raw_s1_q <= RAW_IDLE;
         raw_s2_q <= RAW_IDLE;
      end else begin
         raw_s1_q <= {mode_select_pins, hw_standby_in, reset_req_pin_b, port3_pins_in,
                      port2_pins_in, port1_pins_in, port0_pins_in};
         raw_s2_q <= raw_s1_q;
      end
   end

   assign pin_s[0]   = raw_s2_q[7:0];
   assign pin_s[1]   = raw_s2_q[15:8];
   assign pin_s[2]   = raw_s2_q[23:16];
   assign pin_s[3]   = {4'h0, raw_s2_q[27:24]};
   assign rstreq_b_s = raw_s2_q[28];
   assign stby_s     = raw_s2_q[29];
   assign mode_s     = raw_s2_q[32:30];

   ////////////////////////////////////////////////////////////////////////////
   // mode from pins
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mode_q     <= pinmux_pkg::MODE_SINGLE_CHIP;
         ext_mode_q <= 1'b0;
      end else begin
         mode_q     <= mode_s;
         ext_mode_q <= (mode_s != pinmux_pkg::MODE_SINGLE_CHIP);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         stby_q            <= 1'b0;
         hw_standby_active <= 1'b0;
         reset_request     <= 1'b0;
      end else begin
         stby_q            <= stby_s;
         hw_standby_active <= stby_s;
         reset_request     <= ~rstreq_b_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            pdr_q[i] <= pinmux_pkg::PDR_RESET;
            ddr_q[i] <= pinmux_pkg::DDR_RESET;
         end
         ctrl_q <= pinmux_pkg::CTRL_RESET;
      end else if (reg_wr) begin
         if (in_bank(reg_addr, pinmux_pkg::ADDR_PDR_BASE)) begin
            pdr_q[reg_addr[3:2]] <= reg_wdata;
         end else if (in_bank(reg_addr, pinmux_pkg::ADDR_DDR_BASE)) begin
            ddr_q[reg_addr[3:2]] <= reg_wdata;
         end else if (reg_addr == pinmux_pkg::ADDR_CTRL) begin
            ctrl_q <= reg_wdata[6:0];
         end
      end
   end

   // Port reads return the pin level, so inputs are visible
   always_comb begin
      rdata_d = 8'h00;
      if (in_bank(reg_addr, pinmux_pkg::ADDR_PDR_BASE)) begin
         rdata_d = pin_s[reg_addr[3:2]];
      end else if (in_bank(reg_addr, pinmux_pkg::ADDR_DDR_BASE)) begin
         rdata_d = ddr_q[reg_addr[3:2]];
      end else if (reg_addr == pinmux_pkg::ADDR_CTRL) begin
         rdata_d = {1'b0, ctrl_q};
      end else if (reg_addr == pinmux_pkg::ADDR_STAT) begin
         rdata_d[pinmux_pkg::STAT_EXT_BIT]                        = ext_mode_q;
         rdata_d[pinmux_pkg::STAT_STBY_BIT]                       = stby_q;
         rdata_d[pinmux_pkg::STAT_MODE_LSB +: 3]                  = mode_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin function selection
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         out_d[i] = pdr_q[i];
         oe_d[i]  = ddr_q[i];
      end
      if (ext_mode_q) begin
         out_d[0] = bus_req.ale ? bus_req.addr[7:0] : bus_req.dout[7:0];
         oe_d[0]  = (bus_req.ale || bus_req.dout_en) ? pinmux_pkg::ALL_ON
                                                     : pinmux_pkg::ALL_OFF;
         out_d[1] = bus_req.ale ? bus_req.addr[15:8] : bus_req.dout[15:8];
         oe_d[1]  = oe_d[0];
         out_d[3][0] = bus_req.ale;
         oe_d[3][0]  = 1'b1;
         out_d[3][1] = ~bus_req.rd;
         oe_d[3][1]  = 1'b1;
         // low write strobe, same pin for byte writes
         if (ctrl_q.wrl_en) begin
            out_d[3][2] = ~bus_req.wr_lo;
            oe_d[3][2]  = 1'b1;
         end
         // high strobe only on 16-bit bus, else port
         if (ctrl_q.bus16 && ctrl_q.wrh_en) begin
            out_d[3][3] = ~bus_req.wr_hi;
            oe_d[3][3]  = 1'b1;
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (ext_mode_q && ctrl_q.ua_en[i]) begin
            out_d[2][i] = bus_req.addr[16+i];
            oe_d[2][i]  = 1'b1;
         end
      end
      // timer outputs take their pins when enabled
      for (int i = 0; i < 2; i++) begin
         if (reload_timer_out_en[i]) begin
            out_d[2][6+i] = reload_timer_out[i];
            oe_d[2][6+i]  = 1'b1;
         end
      end
      // Standby floats every pin so the board can power down
      if (stby_q) begin
         for (int i = 0; i < 4; i++) begin
            oe_d[i] = pinmux_pkg::ALL_OFF;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         port0_pins_out <= 8'h00;
         port0_pins_oe  <= 8'h00;
         port1_pins_out <= 8'h00;
         port1_pins_oe  <= 8'h00;
         port2_pins_out <= 8'h00;
         port2_pins_oe  <= 8'h00;
         port3_pins_out <= 4'h0;
         port3_pins_oe  <= 4'h0;
      end else begin
         port0_pins_out <= out_d[0];
         port0_pins_oe  <= oe_d[0];
         port1_pins_out <= out_d[1];
         port1_pins_oe  <= oe_d[1];
         port2_pins_out <= out_d[2];
         port2_pins_oe  <= oe_d[2];
         port3_pins_out <= out_d[3][3:0];
         port3_pins_oe  <= oe_d[3][3:0];
      end
   end

   // Inputs that other blocks read from the pins
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         bus_din               <= 16'h0000;
         reload_timer_event_in <= 2'h0;
         wakeup_irq_inputs     <= pinmux_pkg::WAKE_IDLE;
      end else begin
         bus_din               <= {pin_s[1], pin_s[0]};
         reload_timer_event_in <= pin_s[2][5:4];
         wakeup_irq_inputs     <= ext_mode_q ? pinmux_pkg::WAKE_IDLE : pin_s[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_low_byte_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ext_mode_q && !stby_q && bus_req.ale) |=>
         (port0_pins_out == $past(bus_req.addr[7:0])) && (port0_pins_oe == 8'hFF))
      else $error("low byte address not driven");
   a_high_byte_data: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ext_mode_q && !stby_q && !bus_req.ale && bus_req.dout_en) |=>
         (port1_pins_out == $past(bus_req.dout[15:8])) && (port1_pins_oe == 8'hFF))
      else $error("high byte data not driven");
   a_single_chip_ports: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!ext_mode_q && !stby_q) |=> (port0_pins_oe == $past(ddr_q[0]))
         && (port3_pins_out[1:0] == $past(pdr_q[3][1:0])))
      else $error("bus pins not returned to ports");
   a_wakeup_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      ext_mode_q |=> (wakeup_irq_inputs == 8'hFF))
      else $error("wake-up inputs active in bus mode");
   a_upper_addr_port: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!ext_mode_q && !stby_q) |=> (port2_pins_oe[3:0] == $past(ddr_q[2][3:0])))
      else $error("upper address pins not ports");
   a_upper_addr_drive: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ext_mode_q && !stby_q && ctrl_q.ua_en[3]) |=>
         port2_pins_oe[3] && (port2_pins_out[3] == $past(bus_req.addr[19])))
      else $error("address bit 19 not driven");
   a_event_sample: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 (reload_timer_event_in == $past(raw_s2_q[21:20])))
      else $error("timer event input not forwarded");
   a_timer_out_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reload_timer_out_en[1] && !stby_q) |=>
         port2_pins_oe[7] && (port2_pins_out[7] == $past(reload_timer_out[1])))
      else $error("timer output not on pin");
   a_ale_read_pins: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ext_mode_q && !stby_q) |=> (port3_pins_oe[1:0] == 2'h3) &&
         (port3_pins_out[0] == $past(bus_req.ale)) &&
         (port3_pins_out[1] == !$past(bus_req.rd)))
      else $error("latch enable or read strobe wrong");
   a_write_low: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ext_mode_q && !stby_q && ctrl_q.wrl_en && bus_req.wr_lo) |=>
         port3_pins_oe[2] && !port3_pins_out[2])
      else $error("low write strobe missing");
   a_write_high_8bit: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!ctrl_q.bus16 || !ext_mode_q) |=> (port3_pins_oe[3] == ($past(ddr_q[3][3]) &&
         !$past(stby_q)))) 
      else $error("high write strobe in wrong mode");
   a_write_high: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ext_mode_q && !stby_q && ctrl_q.bus16 && ctrl_q.wrh_en) |=>
         port3_pins_oe[3] && (port3_pins_out[3] == !$past(bus_req.wr_hi)))
      else $error("high write strobe missing");
   a_mode_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 (ext_mode_q == ($past(raw_s2_q[32:30]) != 3'h3)))
      else $error("mode decode wrong");
   a_reset_request: assert property (@(posedge core_clk) disable iff (!rst_b)
      !raw_s2_q[28] |=> reset_request)
      else $error("reset request not raised");
   a_standby_float: assert property (@(posedge core_clk) disable iff (!rst_b)
      stby_q |=> (port0_pins_oe == 8'h00) && (port2_pins_oe == 8'h00)
         && (port3_pins_oe == 4'h0))
      else $error("pins driven in standby");

endmodule

// ### dv/ext_bus_memory.sv
`timescale 1ns/10ps
module ext_bus_memory #(
   parameter logic [15:0] READ_WORD = 16'hC3A5
) (
   // Clock
   input  wire logic        core_clk,
   // Board level pins
   input  wire logic [15:0] bus_pins,
   input  wire logic        bus_oe,
   input  wire logic [3:0]  strobe_pins,
   // Memory drive
   output logic      [15:0] mem_d,
   output logic             mem_oe,
   output logic      [15:0] wr_word
);
   logic [15:0] addr_q;
   ////////////////////////////////////////
   // Address latched while the latch enable is high
   always_ff @(posedge core_clk) begin
      if (strobe_pins[0]) begin
         addr_q <= bus_pins;
      end
   end
   // Bytes captured while their strobe is low
   always_ff @(posedge core_clk) begin
      if (!strobe_pins[2]) begin
         wr_word[7:0] <= bus_pins[7:0];
      end
      if (!strobe_pins[3]) begin
         wr_word[15:8] <= bus_pins[15:8];
      end
   end
   ////////////////////////////////////////
   // Drives only when the device has let go, so a clash shows as a wrong word
   assign mem_oe = !strobe_pins[1] && !bus_oe;
   assign mem_d  = READ_WORD ^ addr_q;
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
module tb;
   logic                 core_clk  = 1'h0;
   logic                 rst_b     = 1'h0;
   logic [5:0]           reg_addr  = 6'h00;
   logic [7:0]           reg_wdata = 8'h00;
   logic                 reg_wr    = 1'h0;
   logic                 reg_rd    = 1'h0;
   pinmux_pkg::bus_req_t bus_req   = '0;
   logic [1:0]           tmr_out   = 2'h0;
   logic [1:0]           tmr_en    = 2'h0;
   logic [2:0]           mode      = 3'h3;
   logic                 stby      = 1'h0;
   logic                 rst_req_b = 1'h1;
   logic [7:0]           gp2       = 8'h00;
   logic [7:0]           reg_rdata, wakeup, p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
   logic [7:0]           p2_in, p2_out, p2_oe;
   logic [3:0]           p3_in, p3_out, p3_oe;
   logic [15:0]          bus_din, mem_d, wr_word;
   logic [1:0]           event_in;
   logic                 stby_act, rst_req, mem_oe;
   logic [15:0]          ctl_tab [5] = '{16'h7FFF, 16'h5EE7, 16'h3FF7, 16'h6FFB, 16'h700F};
   int                   err_count = 0;
   int                   n_checks  = 0;
   ////////////////////////////////////////
   // Released lines fall back to a pattern unlike the last driven value
   assign p0_in = (p0_out & p0_oe) | (~p0_oe & (mem_oe ? mem_d[7:0] : 8'h3C));
   assign p1_in = (p1_out & p1_oe) | (~p1_oe & (mem_oe ? mem_d[15:8] : 8'hC3));
   assign p2_in = (p2_out & p2_oe) | (~p2_oe & gp2);
   assign p3_in = (p3_out & p3_oe) | (~p3_oe & 4'hE);
   ext_bus_pin_mux u_dut (
      .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req),
      .bus_din(bus_din), .reload_timer_out(tmr_out), .reload_timer_out_en(tmr_en),
      .reload_timer_event_in(event_in), .wakeup_irq_inputs(wakeup),
      .mode_select_pins(mode), .hw_standby_in(stby), .reset_req_pin_b(rst_req_b),
      .hw_standby_active(stby_act), .reset_request(rst_req),
      .port0_pins_in(p0_in), .port0_pins_out(p0_out), .port0_pins_oe(p0_oe),
      .port1_pins_in(p1_in), .port1_pins_out(p1_out), .port1_pins_oe(p1_oe),
      .port2_pins_in(p2_in), .port2_pins_out(p2_out), .port2_pins_oe(p2_oe),
      .port3_pins_in(p3_in), .port3_pins_out(p3_out), .port3_pins_oe(p3_oe));
   ext_bus_memory u_mem (
      .core_clk(core_clk), .bus_pins({p1_in, p0_in}), .bus_oe(|p0_oe),
      .strobe_pins(p3_in), .mem_d(mem_d), .mem_oe(mem_oe), .wr_word(wr_word));
   ////////////////////////////////////////
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %0s: expected %0h, seen %0h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      chk(what, exp, reg_rdata);
   endtask
   // Address is fixed; one edge lets the pins follow
   task automatic bus(input logic al, rs, wl, wh, en, input logic [15:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: 20'h12345, ale: al, rd: rs, wr_lo: wl, wr_hi: wh, dout: d, dout_en: en};
      step(1);
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #200000;
      err_count++;
      $display("unexpected run length: expected end, seen none");
      complete_run();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'h1;
      step(5);
      rd(6'h20, 8'h7F, "ctrl");
      rd(6'h10, 8'h00, "ddr0");
      rd(6'h24, 8'h0C, "stat");
      chk("reset oe", 20'h0, {p0_oe, p1_oe, p3_oe});
      wr(6'h3C, 8'hFF);
      rd(6'h3C, 8'h00, "unmapped");
      $display("test reset finished");
      // Bus requests must be ignored in single-chip mode
      bus(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 16'hBEEF);
      wr(6'h10, 8'hFF);
      wr(6'h00, 8'hA5);
      wr(6'h1C, 8'h0F);
      wr(6'h0C, 8'h05);
      @(posedge core_clk);
      gp2 <= 8'h20;
      tmr_en <= 2'h1;
      tmr_out <= 2'h1;
      step(5);
      chk("port0", 20'hFFA5, {p0_oe, p0_out});
      chk("port3", 20'hF5, {p3_oe, p3_out});
      chk("port1 oe", 20'h0, p1_oe);
      chk("wakeup", 20'hC3, wakeup);
      rd(6'h04, 8'hC3, "pin1");
      chk("event", 20'h2, event_in);
      chk("port2", 20'h81, {p2_oe, p2_out[6]});
      wr(6'h10, 8'h00);
      wr(6'h1C, 8'h00);
      @(posedge core_clk);
      tmr_en <= 2'h0;
      bus(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0000);
      $display("test single chip finished");
      for (int m = 0; m < 8; m++) begin
         @(posedge core_clk);
         mode <= m[2:0];
         step(5);
         rd(6'h24, {3'h0, m[2:0], 1'h0, m[2:0] != 3'h3}, "stat");
      end
      chk("wakeup idle", 20'hFF, wakeup);
      $display("test modes finished");
      bus(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0000);
      chk("address", 20'h12345, {p2_out[3:0], p1_out, p0_out});
      chk("address oe", 20'hFFFF, {p1_oe, p0_oe});
      chk("latch", 20'hFFF, {p2_oe[3:0], p3_oe, p3_out});
      bus(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0000);
      chk("read", 20'hFC00, {p3_oe, p3_out, p0_oe});
      step(4);
      chk("read data", 20'hC3A5 ^ 20'h2345, bus_din);
      bus(1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 16'hBEEF);
      chk("write", 20'h2FFFF, {p3_out, p1_oe, p0_oe});
      chk("write data", 20'hBEEF, {p1_out, p0_out});
      bus(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0000);
      chk("captured", 20'hBEEF, wr_word);
      chk("idle", 20'hE, p3_out);
      $display("test bus cycles finished");
      foreach (ctl_tab[i]) begin
         wr(6'h20, ctl_tab[i][15:8]);
         step(2);
         chk("ctrl oe", ctl_tab[i][7:0], {p2_oe[3:0], p3_oe});
      end
      wr(6'h20, 8'h7F);
      $display("test control finished");
      @(posedge core_clk);
      stby <= 1'h1;
      rst_req_b <= 1'h0;
      step(5);
      chk("standby", 20'h3, {stby_act, rst_req});
      chk("standby oe", 20'h0, {p0_oe, p2_oe, p3_oe});
      @(posedge core_clk);
      stby <= 1'h0;
      rst_req_b <= 1'h1;
      step(5);
      chk("resume", 20'hF, {stby_act, rst_req, p3_oe});
      $display("test standby finished");
      complete_run();
   end
endmodule
